// ===== include/dpct_pkg.sv
// Package with register map, field layouts and shared types of the dual counter/timer block.
`default_nettype none
package dpct_pkg;

  // ****************************************
  // Register indices (byte address is index times four)
  // ****************************************
  localparam logic [7:0] IDX_PIN_CTRL       = 8'hf0;
  localparam logic [7:0] IDX_MODE           = 8'hf1;
  localparam logic [7:0] IDX_SECOND_COUNT   = 8'hf2;
  localparam logic [7:0] IDX_SECOND_PRESCALE = 8'hf3;
  localparam logic [7:0] IDX_FIRST_COUNT    = 8'hf4;
  localparam logic [7:0] IDX_FIRST_PRESCALE = 8'hf5;

  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned COUNT_W   = 8;
  localparam int unsigned PRE_W     = 6;

  // ****************************************
  // Values after reset and fixed counts
  // ****************************************
  localparam logic [7:0] PRE_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [2:0] PIN_RESET   = 3'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_LAST  = 8'h01;
  localparam logic [1:0] INT_DIV_LAST = 2'h3;

  // ****************************************
  // Modes and field layouts
  // ****************************************
  typedef enum logic [1:0] {
    TIN_CLOCK  = 2'b00,
    TIN_GATE   = 2'b01,
    TIN_TRIG   = 2'b10,
    TIN_RETRIG = 2'b11
  } dpct_tin_t;

  typedef enum logic [1:0] {
    TIMER_OUTPUT_PIN_PORT   = 2'b00,
    TIMER_OUTPUT_PIN_FIRST  = 2'b01,
    TIMER_OUTPUT_PIN_SECOND = 2'b10,
    TIMER_OUTPUT_PIN_CLOCK  = 2'b11
  } dpct_timer_output_pin_t;

  // Prescale register: divide in [7:2] (0 means 64), continuous in [1], internal source in [0].
  typedef struct packed {
    logic [5:0] divide;
    logic       cont;
    logic       src_int;
  } dpct_pre_t;

  typedef struct packed {
    dpct_timer_output_pin_t timer_output_pin;
    dpct_tin_t  timer_external_input;
    logic       run1;
    logic       load1;
    logic       run0;
    logic       load0;
  } dpct_mode_t;

  typedef struct packed {
    logic port_val;
    logic tin_en;
    logic cascade;
  } dpct_pin_t;

endpackage
`default_nettype wire

// ===== src/dpct_counter.sv
// Eight-bit down counter with single-pass and modulo-n reload.
`timescale 1ns/1ns
`default_nettype none
module dpct_counter
  import dpct_pkg::*;
#(
  parameter int unsigned W = COUNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         run,
  input  wire logic         cont,
  input  wire logic [W-1:0] init,
  output logic      [W-1:0] count,
  output logic              active,
  output logic              eoc,
  output logic              out
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         halted_q;
  logic         halted_d;
  logic         eoc_q;
  logic         eoc_d;
  logic         out_q;
  logic         out_d;

  // Halted from reset so that nothing counts before the first load.
  assign active = run & ~halted_q;
  assign count  = count_q;
  assign eoc    = eoc_q;
  assign out    = out_q;

  always_comb begin
    count_d  = count_q;
    halted_d = halted_q;
    eoc_d    = 1'b0;
    out_d    = out_q;
    if (load) begin
      count_d  = init;
      halted_d = 1'b0;
    end else if (tick && active) begin
      if (count_q == W'(COUNT_LAST)) begin
        eoc_d = 1'b1;
        out_d = ~out_q;
        if (cont) begin
          count_d = init;
        end else begin
          count_d  = '0;
          halted_d = 1'b1;
        end
      end else begin
        count_d = count_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q  <= W'(COUNT_RESET);
      halted_q <= 1'b1;
      eoc_q    <= 1'b0;
      out_q    <= 1'b0;
    end else begin
      count_q  <= count_d;
      halted_q <= halted_d;
      eoc_q    <= eoc_d;
      out_q    <= out_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_tick;
    tick && active && !load && count_q == W'(COUNT_LAST);
  endsequence

  property p_reload;
    (s_last_tick and cont) |=> count_q == $past(init) && eoc_q;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Continuous mode did not reload on the end tick.");

  property p_single_pass;
    (s_last_tick and !cont) |=> count_q == '0 && !active ##1 !eoc_q;
  endproperty
  a_single_pass: assert property (p_single_pass)
    else $error("Single pass did not halt at zero.");

  property p_decrement;
    (tick && active && !load && count_q != W'(COUNT_LAST)) |=> count_q == $past(count_q) - W'(1);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("Counter did not decrement on its tick.");

  property p_stopped_holds;
    (!active && !load) |=> count_q == $past(count_q);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("Stopped counter changed.");

endmodule
`default_nettype wire

// ===== src/dpct_prescaler.sv
// Programmable divide-by-1-to-64 prescaler.
`timescale 1ns/1ns
`default_nettype none
module dpct_prescaler
  import dpct_pkg::*;
#(
  parameter int unsigned W = PRE_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divide,
  output logic              tick_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] lim;

  // A divide of zero wraps to all ones, which gives the longest ratio.
  // Compared as at-or-above, so a divide lowered while counting cannot run past its limit and wrap.
  assign lim      = divide - W'(1);
  assign tick_out = tick_in & ~clear & (cnt_q >= lim);

  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (tick_in) begin
      cnt_d = (cnt_q >= lim) ? '0 : cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  property p_divide_one;
    @(posedge clk) disable iff (rst)
      (tick_in && !clear && divide == W'(1)) |-> tick_out;
  endproperty
  a_divide_one: assert property (p_divide_one)
    else $error("Divide by one did not tick every cycle.");

endmodule
`default_nettype wire

// ===== src/dpct_top.sv
// Dual prescaled counter/timer block with its APB register slave.
//
// Contract
// - Two independent 8-bit down counters, each with its own 6-bit prescaler.
// - First prescaler takes internal clock only; second selects internal or external.
// - Each prescaler divides its source by any integer 1 to 64.
// - Counter decrements once per prescaler tick from a loaded 1 to 256 value.
// - End of count raises the first or second timer request.
// - Software can start, stop, continue or restart from the initial value.
// - Each counter halts at zero or reloads and keeps counting.
// - Counts are readable any time without disturbance; prescalers are not readable.
// - Second clock source is internal clock over four or the external input.
// - External input acts as clock, retriggerable or single trigger, or gate.
// - Cascade option feeds the first timer output into the second timer.
// - Output port line shows first timer, second timer or internal clock; the code's clock option shows clk_tog_q, the input clock divided by two.
// - Internal clock is the input clock with no divide by two.
// - External input and output are alternate pin functions under software control.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dpct_top
  import dpct_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              TIMER_EXTERNAL_INPUT,
  output logic                   FIRST_TIMER_REQUEST,
  output logic                   SECOND_TIMER_REQUEST,
  output logic                   TIMER_OUTPUT_PORT_LINE
);

  // ****************************************
  // Declarations
  // ****************************************
  dpct_pre_t   first_prescale_register_q, first_prescale_register_d;
  dpct_pre_t   pre1_q, pre1_d;
  dpct_mode_t  mode_q, mode_d;
  dpct_pin_t   pin_q, pin_d;
  logic [7:0]  init0_q, init0_d;
  logic [7:0]  init1_q, init1_d;
  logic [31:0] prdata_q, prdata_d;

  logic [1:0]  div4_q, div4_d;
  logic        clk_tog_q, clk_tog_d;
  logic        timer_output_pin_q, timer_output_pin_d;
  logic        tin_s1_q, tin_s2_q, tin_s3_q;

  logic [7:0]  idx, count0, count1;
  logic        hit, setup, access, wr;
  logic        load0, load1, trig1, int4_tick;
  logic        tin_lvl, tin_edge, src1_tick;
  logic        tick0, tick1, act0, act1, out0, out1;

  // ****************************************
  // APB slave
  // ****************************************
  assign idx    = PADDR[9:2];
  assign hit    = (PADDR[ADDR_W-1:10] == '0) && (PADDR[1:0] == 2'h0) &&
                  (idx >= IDX_PIN_CTRL) && (idx <= IDX_FIRST_PRESCALE);
  assign setup  = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr     = access & PWRITE & hit;

  // Zero wait states: every access completes in its first access cycle.
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~hit;
  assign PRDATA  = prdata_q;

  // Load bits act as strobes and are never stored.
  assign load0 = wr & (idx == IDX_MODE) & PWDATA[0];
  assign load1 = (wr & (idx == IDX_MODE) & PWDATA[2]) | trig1;

  always_comb begin
    first_prescale_register_d   = first_prescale_register_q;
    pre1_d   = pre1_q;
    mode_d   = mode_q;
    pin_d    = pin_q;
    init0_d  = init0_q;
    init1_d  = init1_q;
    prdata_d = prdata_q;
    if (wr) begin
      unique case (idx)
        IDX_FIRST_PRESCALE: begin
          // The first timer never uses the source bit; it is always stored as internal.
          first_prescale_register_d         = dpct_pre_t'(PWDATA[7:0]);
          first_prescale_register_d.src_int = 1'b1;
        end
        IDX_SECOND_PRESCALE: pre1_d = dpct_pre_t'(PWDATA[7:0]);
        IDX_FIRST_COUNT:     init0_d = PWDATA[7:0];
        IDX_SECOND_COUNT:    init1_d = PWDATA[7:0];
        IDX_MODE: begin
          mode_d       = dpct_mode_t'(PWDATA[7:0]);
          mode_d.load0 = 1'b0;
          mode_d.load1 = 1'b0;
        end
        IDX_PIN_CTRL:        pin_d = dpct_pin_t'(PWDATA[2:0]);
        default: ;
      endcase
    end
    // Read data is captured in the setup cycle so it comes from a flop.
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (hit && !PWRITE) begin
        unique case (idx)
          IDX_FIRST_COUNT:  prdata_d[7:0] = count0;
          IDX_SECOND_COUNT: prdata_d[7:0] = count1;
          IDX_MODE:         prdata_d[7:0] = mode_q;
          IDX_PIN_CTRL:     prdata_d[2:0] = pin_q;
          default:          prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      first_prescale_register_q   <= dpct_pre_t'(PRE_RESET);
      pre1_q   <= dpct_pre_t'(PRE_RESET);
      mode_q   <= dpct_mode_t'(MODE_RESET);
      pin_q    <= dpct_pin_t'(PIN_RESET);
      init0_q  <= COUNT_RESET;
      init1_q  <= COUNT_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      first_prescale_register_q   <= first_prescale_register_d;
      pre1_q   <= pre1_d;
      mode_q   <= mode_d;
      pin_q    <= pin_d;
      init0_q  <= init0_d;
      init1_q  <= init1_d;
      prdata_q <= prdata_d;
    end
  end

  // ****************************************
  // External input synchroniser and clock dividers
  // ****************************************
  // The input is only looked at past the second flop; the third gives the edge.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tin_s1_q <= 1'b0;
      tin_s2_q <= 1'b0;
      tin_s3_q <= 1'b0;
    end else begin
      tin_s1_q <= TIMER_EXTERNAL_INPUT;
      tin_s2_q <= tin_s1_q;
      tin_s3_q <= tin_s2_q;
    end
  end

  // With the alternate function off the input is masked, so the timer sees it as low.
  assign tin_lvl  = pin_q.tin_en & tin_s2_q;
  assign tin_edge = pin_q.tin_en & tin_s2_q & ~tin_s3_q;

  assign int4_tick = (div4_q == INT_DIV_LAST);

  always_comb begin
    div4_d    = div4_q + 2'h1;
    clk_tog_d = ~clk_tog_q;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div4_q    <= 2'h0;
      clk_tog_q <= 1'b0;
    end else begin
      div4_q    <= div4_d;
      clk_tog_q <= clk_tog_d;
    end
  end

  // ****************************************
  // Second timer source selection
  // ****************************************
  always_comb begin
    src1_tick = 1'b0;
    trig1     = 1'b0;
    if (pin_q.cascade) begin
      src1_tick = FIRST_TIMER_REQUEST;
    end else if (!pre1_q.src_int) begin
      src1_tick = tin_edge;
    end else if (pin_q.tin_en) begin
      unique case (mode_q.timer_external_input)
        TIN_CLOCK:  src1_tick = int4_tick;
        TIN_GATE:   src1_tick = int4_tick & tin_lvl;
        TIN_TRIG: begin
          src1_tick = int4_tick;
          trig1     = tin_edge & ~act1;
        end
        TIN_RETRIG: begin
          src1_tick = int4_tick;
          trig1     = tin_edge;
        end
      endcase
    end else begin
      src1_tick = int4_tick;
    end
  end

  // ****************************************
  // Prescalers and counters
  // ****************************************
  // The core clock is used undivided, so the first source ticks every cycle.
  dpct_prescaler #(.W(PRE_W)) u_first_prescale_register (
    .clk      (CLOCK),
    .rst      (RST),
    .clear    (load0),
    .tick_in  (act0),
    .divide   (first_prescale_register_q.divide),
    .tick_out (tick0)
  );

  dpct_counter #(.W(COUNT_W)) u_cnt0 (
    .clk    (CLOCK),
    .rst    (RST),
    .tick   (tick0),
    .load   (load0),
    .run    (mode_q.run0),
    .cont   (first_prescale_register_q.cont),
    .init   (init0_q),
    .count  (count0),
    .active (act0),
    .eoc    (FIRST_TIMER_REQUEST),
    .out    (out0)
  );

  dpct_prescaler #(.W(PRE_W)) u_pre1 (
    .clk      (CLOCK),
    .rst      (RST),
    .clear    (load1),
    .tick_in  (src1_tick & act1),
    .divide   (pre1_q.divide),
    .tick_out (tick1)
  );

  dpct_counter #(.W(COUNT_W)) u_cnt1 (
    .clk    (CLOCK),
    .rst    (RST),
    .tick   (tick1),
    .load   (load1),
    .run    (mode_q.run1),
    .cont   (pre1_q.cont),
    .init   (init1_q),
    .count  (count1),
    .active (act1),
    .eoc    (SECOND_TIMER_REQUEST),
    .out    (out1)
  );

  // ****************************************
  // Output port line
  // ****************************************
  always_comb begin
    unique case (mode_q.timer_output_pin)
      TIMER_OUTPUT_PIN_PORT:   timer_output_pin_d = pin_q.port_val;
      TIMER_OUTPUT_PIN_FIRST:  timer_output_pin_d = out0;
      TIMER_OUTPUT_PIN_SECOND: timer_output_pin_d = out1;
      TIMER_OUTPUT_PIN_CLOCK:  timer_output_pin_d = clk_tog_q;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      timer_output_pin_q <= 1'b0;
    end else begin
      timer_output_pin_q <= timer_output_pin_d;
    end
  end

  assign TIMER_OUTPUT_PORT_LINE = timer_output_pin_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // Counter and prescaler checks sit in their own modules and so watch both timers.
  property p_first_request;
    FIRST_TIMER_REQUEST |-> $past(tick0 && act0 && count0 == 8'h01);
  endproperty
  a_first_request: assert property (p_first_request)
    else $error("First request without its end of count.");

  property p_second_request;
    SECOND_TIMER_REQUEST |-> $past(tick1 && act1 && count1 == 8'h01);
  endproperty
  a_second_request: assert property (p_second_request)
    else $error("Second request without its end of count.");

  property p_div4;
    int4_tick |=> !int4_tick [*3] ##1 int4_tick;
  endproperty
  a_div4: assert property (p_div4)
    else $error("Internal divide by four is off.");

  property p_prescale_unread;
    (setup && !PWRITE && idx == IDX_FIRST_PRESCALE) |=> PRDATA == 32'h0000_0000;
  endproperty
  a_prescale_unread: assert property (p_prescale_unread)
    else $error("Prescale register returned data.");

  property p_sync_edge;
    tin_edge |-> $past(TIMER_EXTERNAL_INPUT, 2) && !$past(TIMER_EXTERNAL_INPUT, 3);
  endproperty
  a_sync_edge: assert property (p_sync_edge)
    else $error("Input edge not taken through the synchroniser.");

  property p_no_retrigger;
    (act1 && mode_q.timer_external_input == TIN_TRIG) |-> !trig1;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("Single trigger restarted a running timer.");

  property p_timer_output_pin_first;
    $past(mode_q.timer_output_pin == TIMER_OUTPUT_PIN_FIRST) |-> TIMER_OUTPUT_PORT_LINE == $past(out0);
  endproperty
  a_timer_output_pin_first: assert property (p_timer_output_pin_first)
    else $error("Output line does not follow the first timer.");

endmodule
`default_nettype wire

// ===== test/dpct_ext_model.sv
// Behavioural model of the source that drives the external timer input line.
`timescale 1ns/1ns
`default_nettype none
module dpct_ext_model (
  input  wire logic clk,
  output logic      line
);
  // ****************************************
  // Line stimulus
  // ****************************************
  // The line idles low; each pulse is held for three clocks so the synchroniser sees it.
  initial begin
    line = 1'b0;
  end

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk) line <= 1'b1;
      repeat (3) @(posedge clk);
      line <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic level(input logic v);
    @(posedge clk) line <= v;
  endtask
endmodule
`default_nettype wire

// ===== test/dpct_top_tb.sv
// Self-checking testbench of the dual prescaled counter/timer block.
`timescale 1ns/1ns
`default_nettype none
module dpct_top_tb
  import dpct_pkg::*;
;
  logic              clk, rst, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, req0, req1, timer_output_pin;
  wire logic         ext_line;
  int                fails, checked;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dpct_top DUT (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMER_EXTERNAL_INPUT(ext_line),
    .FIRST_TIMER_REQUEST(req0), .SECOND_TIMER_REQUEST(req1), .TIMER_OUTPUT_PORT_LINE(timer_output_pin));

  dpct_ext_model EXT (.clk(clk), .line(ext_line));

  // ****************************************
  // Bus, wait and compare helpers
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] v,
                     output logic [31:0] d, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, v};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, v, d, e);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
  endtask

  // Counts clocks after the call until the chosen request is seen; lim+1 means none came.
  task automatic wait_req(input logic sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (((sel ? req1 : req0) !== 1'b1) && n <= lim);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 6; i++) begin
      rd(8'hf0 + i[7:0], d);
      chk(d, 32'h00000000);
    end
    apb(1'b0, 8'hf6, 8'h00, d, e);
    chk({d[30:0], e}, 32'h00000001);
    wr(IDX_FIRST_PRESCALE, 8'h55);
    rd(IDX_FIRST_PRESCALE, d);
    chk(d, 32'h00000000);
    wr(IDX_PIN_CTRL, 8'h05);
    rd(IDX_PIN_CTRL, d);
    chk(d, 32'h00000005);
    wr(IDX_PIN_CTRL, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_single();
    int          tn[4] = '{2, 4, 1, 256};
    int          td[4] = '{1, 3, 64, 1};
    int          n;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_FIRST_PRESCALE, {td[i][5:0], 2'b00});
      wr(IDX_FIRST_COUNT, tn[i][7:0]);
      wr(IDX_MODE, 8'h03);
      wait_req(1'b0, 300, n);
      chk(n, tn[i] * td[i]);
      @(posedge clk);
      #1;
      chk(req0, 1'b0);
      wait_req(1'b0, 20, n);
      chk(n, 21);
      rd(IDX_FIRST_COUNT, d);
      chk(d, 32'h00000000);
    end
    $display("test single done");
  endtask

  task automatic t_cont();
    int n;
    wr(IDX_FIRST_PRESCALE, 8'h0e);
    wr(IDX_FIRST_COUNT, 8'h05);
    wr(IDX_MODE, 8'h03);
    wait_req(1'b0, 100, n);
    wait_req(1'b0, 100, n);
    chk(n, 15);
    wait_req(1'b0, 100, n);
    chk(n, 15);
    wr(IDX_MODE, 8'h00);
    $display("test continuous done");
  endtask

  task automatic t_stop();
    logic [31:0] d1, d2;
    wr(IDX_FIRST_PRESCALE, 8'h00);
    wr(IDX_FIRST_COUNT, 8'h0a);
    wr(IDX_MODE, 8'h03);
    rd(IDX_FIRST_COUNT, d1);
    chk(d1, 32'h0000000a);
    repeat (70) @(posedge clk);
    wr(IDX_MODE, 8'h00);
    rd(IDX_FIRST_COUNT, d1);
    chk(d1, 32'h00000009);
    repeat (140) @(posedge clk);
    rd(IDX_FIRST_COUNT, d2);
    chk(d2, d1);
    wr(IDX_MODE, 8'h02);
    rd(IDX_FIRST_COUNT, d2);
    chk(d2, 32'h00000009);
    wr(IDX_MODE, 8'h03);
    rd(IDX_FIRST_COUNT, d2);
    chk(d2, 32'h0000000a);
    wr(IDX_MODE, 8'h00);
    $display("test stop done");
  endtask

  task automatic t_second();
    int          n;
    logic [7:0]  m[2] = '{8'h2c, 8'h3c};
    wr(IDX_SECOND_PRESCALE, 8'h07);
    wr(IDX_SECOND_COUNT, 8'h03);
    wr(IDX_MODE, 8'h0c);
    wait_req(1'b1, 100, n);
    wait_req(1'b1, 100, n);
    chk(n, 12);
    wr(IDX_PIN_CTRL, 8'h02);
    wr(IDX_SECOND_PRESCALE, 8'h06);
    wr(IDX_SECOND_COUNT, 8'h02);
    wr(IDX_MODE, 8'h0c);
    // The request lasts one clock, so the watch runs beside the pulse instead of after it.
    fork
      EXT.pulses(1);
      wait_req(1'b1, 8, n);
    join
    chk(n, 9);
    fork
      EXT.pulses(1);
      wait_req(1'b1, 8, n);
    join
    chk(n < 9, 1'b1);
    wr(IDX_SECOND_PRESCALE, 8'h07);
    wr(IDX_SECOND_COUNT, 8'h01);
    wr(IDX_MODE, 8'h1c);
    wait_req(1'b1, 20, n);
    chk(n, 21);
    EXT.level(1'b1);
    wait_req(1'b1, 12, n);
    chk(n < 13, 1'b1);
    EXT.level(1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_SECOND_PRESCALE, 8'h05);
      wr(IDX_SECOND_COUNT, 8'h02);
      wr(IDX_MODE, m[i]);
      wait_req(1'b1, 20, n);
      chk(n < 21, 1'b1);
      wait_req(1'b1, 20, n);
      chk(n, 21);
      fork
        EXT.pulses(1);
        wait_req(1'b1, 20, n);
      join
      chk(n < 21, 1'b1);
    end
    $display("test second done");
  endtask

  task automatic t_cascade();
    int n;
    wr(IDX_PIN_CTRL, 8'h01);
    wr(IDX_FIRST_PRESCALE, 8'h0a);
    wr(IDX_FIRST_COUNT, 8'h01);
    wr(IDX_SECOND_PRESCALE, 8'h06);
    wr(IDX_SECOND_COUNT, 8'h02);
    wr(IDX_MODE, 8'h0f);
    wait_req(1'b1, 100, n);
    wait_req(1'b1, 100, n);
    chk(n, 4);
    wr(IDX_MODE, 8'h00);
    wr(IDX_PIN_CTRL, 8'h00);
    $display("test cascade done");
  endtask

  task automatic t_out();
    int   n;
    logic a;
    wr(IDX_PIN_CTRL, 8'h04);
    repeat (3) @(posedge clk);
    #1;
    chk(timer_output_pin, 1'b1);
    wr(IDX_PIN_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(timer_output_pin, 1'b0);
    wr(IDX_MODE, 8'hc0);
    @(posedge clk);
    #1;
    a = timer_output_pin;
    @(posedge clk);
    #1;
    chk(timer_output_pin, !a);
    wr(IDX_FIRST_PRESCALE, 8'h04);
    wr(IDX_FIRST_COUNT, 8'h02);
    wr(IDX_MODE, 8'h40);
    @(posedge clk);
    #1;
    a = timer_output_pin;
    wr(IDX_MODE, 8'h43);
    wait_req(1'b0, 20, n);
    repeat (2) @(posedge clk);
    #1;
    chk(timer_output_pin, !a);
    $display("test output done");
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under two thousand clocks; this bound leaves wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    checked = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_cont();
    t_stop();
    t_second();
    t_cascade();
    t_out();
    wrap_up();
  end
endmodule
`default_nettype wire
